// ### core/pvt_pkg.sv
// Notes on behaviour
// - the port number comes from the address nibble N, and ports 1 to 3 each hold their own set of these registers.
// - each port keeps its own copy of every register, so writing one port leaves the others unchanged.
// - the default tag high byte holds PCP in bits 7:5, DEI in bit 4 and VID 11:8 in bits 3:0, and resets to zero.
// - the default tag low byte holds VID 7:0 and resets to one.
// - the class 1 tag high byte holds priority, CFI and VID 11:8, and resets to 0x60.
// - the class 1 tag low byte holds VID 7:0 and resets to 0x02.
// - the class 2 tag high byte uses the class 1 layout and resets to 0x40.
// - the class 2 tag low byte holds VID 7:0 and resets to 0x03.
// - the class 1 EtherType is 16 bits wide over two byte addresses and resets to 0x88B5.
// - the class 2 EtherType is 16 bits wide over two byte addresses and resets to 0x88B5.
package pvt_pkg;
	localparam int ADDR_W = 16;
	localparam logic [3:0] PORT_FIRST = 4'h1;
	localparam logic [3:0] PORT_LAST = 4'h3;
	localparam int NUM_PORTS = 3;
	// register indices; the byte address on the bus is four times the index
	localparam logic [11:0] IDX_DEF_HI = 12'h000;
	localparam logic [11:0] IDX_DEF_LO = 12'h001;
	localparam logic [11:0] IDX_C1_HI = 12'h004;
	localparam logic [11:0] IDX_C1_LO = 12'h005;
	localparam logic [11:0] IDX_C2_HI = 12'h006;
	localparam logic [11:0] IDX_C2_LO = 12'h007;
	localparam logic [11:0] IDX_C1_TYPE = 12'h008;
	localparam logic [11:0] IDX_C2_TYPE = 12'h00A;
	localparam logic [7:0] RST_DEF_HI = 8'h00;
	localparam logic [7:0] RST_DEF_LO = 8'h01;
	localparam logic [7:0] RST_C1_HI = 8'h60;
	localparam logic [7:0] RST_C1_LO = 8'h02;
	localparam logic [7:0] RST_C2_HI = 8'h40;
	localparam logic [7:0] RST_C2_LO = 8'h03;
	localparam logic [15:0] RST_TYPE = 16'h88B5;
endpackage

// ### core/pvt_reg_if.sv
`timescale 1ns/1ps
interface pvt_reg_if;
	logic wr;
	logic [11:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic hit;
	modport bank (input wr, idx, wdata, output rdata, hit);
	modport ctrl (output wr, idx, wdata, input rdata, hit);
endinterface

// ### core/pvt_port_bank.sv
`timescale 1ns/1ps
// one port's private register copy
module pvt_port_bank (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register access
	pvt_reg_if.bank rif,
	// tag values for the port datapath
	output logic [15:0] def_tag,
	output logic [15:0] c1_tag,
	output logic [15:0] c2_tag,
	output logic [15:0] c1_type,
	output logic [15:0] c2_type
);
	logic [7:0] def_hi, def_lo, c1_hi, c1_lo, c2_hi, c2_lo;
	logic [15:0] t1, t2;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			def_hi <= pvt_pkg::RST_DEF_HI;
			def_lo <= pvt_pkg::RST_DEF_LO;
			c1_hi <= pvt_pkg::RST_C1_HI;
			c1_lo <= pvt_pkg::RST_C1_LO;
			c2_hi <= pvt_pkg::RST_C2_HI;
			c2_lo <= pvt_pkg::RST_C2_LO;
			t1 <= pvt_pkg::RST_TYPE;
			t2 <= pvt_pkg::RST_TYPE;
		end else if (rif.wr) begin
			case (rif.idx)
				pvt_pkg::IDX_DEF_HI: def_hi <= rif.wdata;
				pvt_pkg::IDX_DEF_LO: def_lo <= rif.wdata;
				pvt_pkg::IDX_C1_HI: c1_hi <= rif.wdata;
				pvt_pkg::IDX_C1_LO: c1_lo <= rif.wdata;
				pvt_pkg::IDX_C2_HI: c2_hi <= rif.wdata;
				pvt_pkg::IDX_C2_LO: c2_lo <= rif.wdata;
				pvt_pkg::IDX_C1_TYPE: t1[15:8] <= rif.wdata;
				pvt_pkg::IDX_C1_TYPE + 12'h001: t1[7:0] <= rif.wdata;
				pvt_pkg::IDX_C2_TYPE: t2[15:8] <= rif.wdata;
				pvt_pkg::IDX_C2_TYPE + 12'h001: t2[7:0] <= rif.wdata;
				default: ;
			endcase
		end
	end

	always_comb begin
		rif.hit = 1'b1;
		case (rif.idx)
			pvt_pkg::IDX_DEF_HI: rif.rdata = def_hi;
			pvt_pkg::IDX_DEF_LO: rif.rdata = def_lo;
			pvt_pkg::IDX_C1_HI: rif.rdata = c1_hi;
			pvt_pkg::IDX_C1_LO: rif.rdata = c1_lo;
			pvt_pkg::IDX_C2_HI: rif.rdata = c2_hi;
			pvt_pkg::IDX_C2_LO: rif.rdata = c2_lo;
			pvt_pkg::IDX_C1_TYPE: rif.rdata = t1[15:8];
			pvt_pkg::IDX_C1_TYPE + 12'h001: rif.rdata = t1[7:0];
			pvt_pkg::IDX_C2_TYPE: rif.rdata = t2[15:8];
			pvt_pkg::IDX_C2_TYPE + 12'h001: rif.rdata = t2[7:0];
			default: begin
				rif.rdata = 8'h00;
				rif.hit = 1'b0;
			end
		endcase
	end

	assign def_tag = {def_hi, def_lo};
	assign c1_tag = {c1_hi, c1_lo};
	assign c2_tag = {c2_hi, c2_lo};
	assign c1_type = t1;
	assign c2_type = t2;
endmodule

// ### core/pvt_port_tag_regs.sv
`timescale 1ns/1ps
module pvt_port_tag_regs (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// per-port tag values, port 1 at the low slice
	output logic [47:0] def_tag,
	output logic [47:0] c1_tag,
	output logic [47:0] c2_tag,
	output logic [47:0] c1_type,
	output logic [47:0] c2_type
);
	// byte-wide register at word index: paddr[17:2] = {N, register index}
	logic [3:0] port_sel;
	logic [11:0] idx;
	logic port_ok;
	logic setup;
	logic [7:0] rd [pvt_pkg::NUM_PORTS];
	logic hit [pvt_pkg::NUM_PORTS];
	logic [15:0] dt [pvt_pkg::NUM_PORTS];
	logic [15:0] t1 [pvt_pkg::NUM_PORTS];
	logic [15:0] t2 [pvt_pkg::NUM_PORTS];
	logic [15:0] y1 [pvt_pkg::NUM_PORTS];
	logic [15:0] y2 [pvt_pkg::NUM_PORTS];
	logic sel_hit;
	logic [7:0] sel_rd;

	assign port_sel = paddr[17:14];
	assign idx = paddr[13:2];
	assign port_ok = (port_sel >= pvt_pkg::PORT_FIRST) && (port_sel <= pvt_pkg::PORT_LAST);
	// answer one cycle after setup; pready is a flop so the access phase is exactly one cycle
	assign setup = psel && !penable && !pready;

	pvt_reg_if rif [pvt_pkg::NUM_PORTS] ();

	genvar g;
	generate
		for (g = 0; g < pvt_pkg::NUM_PORTS; g++) begin : g_port
			// only the addressed port sees the write strobe
			assign rif[g].wr = setup && pwrite && pstrb[0] && port_ok
				&& (port_sel == 4'(g + 1));
			assign rif[g].idx = idx;
			assign rif[g].wdata = pwdata[7:0];
			assign rd[g] = rif[g].rdata;
			assign hit[g] = rif[g].hit;
			pvt_port_bank u_bank (
				.pclk(pclk),
				.presetn(presetn),
				.rif(rif[g]),
				.def_tag(dt[g]),
				.c1_tag(t1[g]),
				.c2_tag(t2[g]),
				.c1_type(y1[g]),
				.c2_type(y2[g])
			);
		end
	endgenerate

	always_comb begin
		sel_hit = 1'b0;
		sel_rd = 8'h00;
		for (int i = 0; i < pvt_pkg::NUM_PORTS; i++) begin
			if (port_ok && port_sel == 4'(i + 1)) begin
				sel_hit = hit[i];
				sel_rd = rd[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			// unmapped port or index: error, write dropped, read zero
			pslverr <= setup && !sel_hit;
			if (setup && !pwrite) begin
				prdata <= {24'h00_0000, sel_rd};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			def_tag <= {3{pvt_pkg::RST_DEF_HI, pvt_pkg::RST_DEF_LO}};
			c1_tag <= {3{pvt_pkg::RST_C1_HI, pvt_pkg::RST_C1_LO}};
			c2_tag <= {3{pvt_pkg::RST_C2_HI, pvt_pkg::RST_C2_LO}};
			c1_type <= {3{pvt_pkg::RST_TYPE}};
			c2_type <= {3{pvt_pkg::RST_TYPE}};
		end else begin
			def_tag <= {dt[2], dt[1], dt[0]};
			c1_tag <= {t1[2], t1[1], t1[0]};
			c2_tag <= {t2[2], t2[1], t2[0]};
			c1_type <= {y1[2], y1[1], y1[0]};
			c2_type <= {y2[2], y2[1], y2[0]};
		end
	end
endmodule

// ### dv/pvt_port_tag_regs_properties.sv
`timescale 1ns/1ps
module pvt_port_tag_regs_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [47:0] def_tag
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s; psel && !penable && !pready; endsequence
	sequence wr_s; setup_s ##0 pwrite && pstrb[0] && paddr == 18'h04004; endsequence
	a_ready_follows: assert property (setup_s |=> pready) else $error("no ready");
	a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
	a_err_port0: assert property (setup_s ##0 paddr[17:14] == 4'h0 |=> pslverr)
		else $error("port 0 taken");
	a_err_port_hi: assert property (setup_s ##0 paddr[17:14] > 4'h3 |=> pslverr)
		else $error("high port taken");
	a_ok_mapped: assert property (setup_s ##0 paddr == 18'h08014 |=> !pslverr)
		else $error("mapped refused");
	a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper");
	a_def_write: assert property (wr_s |=> ##1 def_tag[7:0] == $past(pwdata[7:0], 2))
		else $error("write lost");
	a_def_isolated: assert property (wr_s |=> ##1 $stable(def_tag[47:16]))
		else $error("other port hit");
endmodule
bind pvt_port_tag_regs pvt_port_tag_regs_properties i_props (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .def_tag);

// ### dv/pvt_port_tag_regs_tb.sv
`timescale 1ns/1ps
`define CK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module pvt_port_tag_regs_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic [47:0] def_tag, c1_tag, c2_tag, c1_type, c2_type;
	int bad_count = 0, check_count = 0, cycles = 0;
	logic [11:0] ix [10] = '{12'h0, 12'h1, 12'h4, 12'h5, 12'h6, 12'h7, 12'h8, 12'h9, 12'hA, 12'hB};
	logic [7:0] rv [10] = '{8'h00, 8'h01, 8'h60, 8'h02, 8'h40, 8'h03, 8'h88, 8'hB5, 8'h88, 8'hB5};
	pvt_port_tag_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .def_tag, .c1_tag, .c2_tag, .c1_type, .c2_type);
	initial begin
		forever #10 pclk = ~pclk;
	end
	// a hung handshake ends here
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic xfer(input logic w, input logic [3:0] n, input logic [11:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {n, i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_reset();
		`CK("def out", {3{16'h0001}}, def_tag)
		`CK("c1 out", {3{16'h6002}}, c1_tag)
		`CK("c2 out", {3{16'h4003}}, c2_tag)
		`CK("t1 out", {3{16'h88B5}}, c1_type)
		for (int k = 0; k < 10; k++) begin
			xfer(1'b0, 4'h2, ix[k], 8'h00);
			`CK("reset", {24'h0, rv[k]}, rd)
			`CK("ok", 1'b0, err)
		end
		`CK("type out", {3{16'h88B5}}, c2_type)
	endtask
	task automatic t_ports();
		for (int k = 0; k < 10; k++) xfer(1'b1, 4'h3, ix[k], 8'hA0 + 8'(k));
		for (int k = 0; k < 10; k++) begin
			xfer(1'b0, 4'h3, ix[k], 8'h00);
			`CK("own", 32'hA0 + k, rd)
			xfer(1'b0, 4'h1, ix[k], 8'h00);
			`CK("other", {24'h0, rv[k]}, rd)
		end
		`CK("type2", 16'hA8A9, c2_type[47:32])
		`CK("def3", 16'hA0A1, def_tag[47:32])
		`CK("c1 3", 16'hA2A3, c1_tag[47:32])
		`CK("c2 3", 16'hA4A5, c2_tag[47:32])
		`CK("type1", 16'hA6A7, c1_type[47:32])
		`CK("low ports", {2{16'h0001}}, def_tag[31:0])
	endtask
	// a second reset in mid-run must bring every port back to its defaults
	task automatic t_rereset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		`CK("rst def", {3{16'h0001}}, def_tag)
		`CK("rst c1", {3{16'h6002}}, c1_tag)
		`CK("rst type", {3{16'h88B5}}, c1_type)
		xfer(1'b0, 4'h3, 12'h004, 8'h00);
		`CK("rst c1 hi", 32'h60, rd)
		`CK("rst ok", 1'b0, err)
	endtask
	task automatic t_refuse();
		xfer(1'b1, 4'h0, 12'h001, 8'h77);
		`CK("port0", 1'b1, err)
		xfer(1'b1, 4'h4, 12'h001, 8'h77);
		`CK("port4", 1'b1, err)
		xfer(1'b0, 4'h1, 12'h002, 8'h00);
		`CK("gap", 32'h0, rd)
		`CK("gap err", 1'b1, err)
		pstrb <= 4'h0;
		xfer(1'b1, 4'h1, 12'h001, 8'h77);
		pstrb <= 4'hF;
		`CK("no err", 1'b0, err)
		// the tag outputs lag the bank by one edge, so wait before judging
		@(posedge pclk);
		`CK("kept", 16'h0001, def_tag[15:0])
		xfer(1'b1, 4'h1, 12'h001, 8'h5A);
		@(posedge pclk);
		`CK("def", 16'h005A, def_tag[15:0])
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_ports();
		t_refuse();
		t_rereset();
		wrap_up();
	end
endmodule
